/* File: rtl/port_block_pkg.sv */
// constants, carriers and register map of the general-purpose port block
package port_block_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_OUT_PORT_A   = 8'h00;
    localparam logic [7:0] ADDR_BIDIR_PORT_B = 8'h04;
    localparam logic [7:0] ADDR_BIDIR_PORT_C = 8'h08;
    localparam logic [7:0] ADDR_BIDIR_PORT_D = 8'h0C;
    localparam logic [7:0] ADDR_IN_PORT_A    = 8'h10;
    localparam logic [7:0] ADDR_OUT_PORT_B   = 8'h14;
    localparam logic [7:0] ADDR_OUT_PORT_C   = 8'h18;
    localparam logic [7:0] ADDR_DIR_B        = 8'h20;
    localparam logic [7:0] ADDR_DIR_CD       = 8'h24;
    localparam logic [7:0] ADDR_PULL_DOWN    = 8'h28;
    localparam logic [7:0] ADDR_CONTROL      = 8'h2C;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int CTRL_CE_RESET_BIT   = 0;
    localparam int CTRL_CLOCK_STOP_BIT = 1;
    localparam int CTRL_HALT_BIT       = 2;
    localparam int DIR_C_LSB           = 0;
    localparam int DIR_D_LSB           = 2;

    localparam logic [3:0] LATCH_RESET     = 4'h0;
    localparam logic [3:0] DIR_RESET       = 4'h0;
    localparam logic [3:0] PULL_DOWN_RESET = 4'hF;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [3:0] portB;
        logic [1:0] portC;
        logic [1:0] portD;
    } bidir_t;

    typedef struct packed {
        logic [3:0] portA;
        logic [3:0] portB;
        logic       portC;
    } outPins_t;

endpackage : port_block_pkg

/* File: rtl/port_block.sv */
// general-purpose port block with apb register access
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module port_block (
    // clock and power-on reset
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // bidirectional port pins
    input  wire port_block_pkg::bidir_t  bidirIn,
    output port_block_pkg::bidir_t       bidirOut,
    output port_block_pkg::bidir_t       bidirOe,
    // input-only port pins
    input  wire logic [3:0]              inPortA,
    output logic      [3:0]              pullDownEn,
    // output-only port pins
    output port_block_pkg::outPins_t     outPins
);
    import port_block_pkg::*;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic        wrEn;
    logic        setup;
    logic        mapped;
    logic        halt_q;
    logic        ceEvent;
    logic        stopEvent;
    logic [3:0]  wrNib;

    assign setup     = psel && !penable;
    assign wrEn      = psel && penable && pready && pwrite;
    assign wrNib     = pwdata[3:0];
    assign ceEvent   = wrEn && paddr == ADDR_CONTROL && pwdata[CTRL_CE_RESET_BIT];
    assign stopEvent = wrEn && paddr == ADDR_CONTROL && pwdata[CTRL_CLOCK_STOP_BIT];

    always_comb begin
        case (paddr)
            ADDR_OUT_PORT_A, ADDR_BIDIR_PORT_B, ADDR_BIDIR_PORT_C, ADDR_BIDIR_PORT_D,
            ADDR_IN_PORT_A, ADDR_OUT_PORT_B, ADDR_OUT_PORT_C, ADDR_DIR_B,
            ADDR_DIR_CD, ADDR_PULL_DOWN, ADDR_CONTROL: mapped = 1'b1;
            default:                                   mapped = 1'b0;
        endcase
    end

    // port writes are dropped while halted, so under halt only a ce reset or clock stop moves anything (it clears direction)
    logic portWr;
    assign portWr = wrEn && !halt_q;

    // ****************************************************************
    // control: halt level
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            halt_q <= 1'b0;
        end else if (wrEn && paddr == ADDR_CONTROL) begin
            halt_q <= pwdata[CTRL_HALT_BIT];
        end
    end

    // ****************************************************************
    // direction select registers
    // ****************************************************************
    logic [3:0] dirB_q;
    logic [3:0] dirCD_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dirB_q  <= DIR_RESET;
            dirCD_q <= DIR_RESET;
        end else if (ceEvent || stopEvent) begin
            dirB_q  <= DIR_RESET;
            dirCD_q <= DIR_RESET;
        end else if (portWr && paddr == ADDR_DIR_B) begin
            dirB_q  <= wrNib;
        end else if (portWr && paddr == ADDR_DIR_CD) begin
            dirCD_q <= wrNib;
        end
    end

    // ****************************************************************
    // bidirectional output latches, kept across ce reset and clock stop
    // ****************************************************************
    logic [3:0] latchB_q;
    logic [1:0] latchC_q;
    logic [1:0] latchD_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            latchB_q <= LATCH_RESET;
            latchC_q <= LATCH_RESET[1:0];
            latchD_q <= LATCH_RESET[1:0];
        end else if (portWr) begin
            // latch updates whatever the direction
            if (paddr == ADDR_BIDIR_PORT_B) latchB_q <= wrNib;
            if (paddr == ADDR_BIDIR_PORT_C) latchC_q <= wrNib[1:0];
            if (paddr == ADDR_BIDIR_PORT_D) latchD_q <= wrNib[3:2];
        end
    end

    // ****************************************************************
    // output-only latches and input pull-downs
    // ****************************************************************
    logic [3:0] outA_q;
    logic [3:0] outB_q;
    logic       outC_q;
    logic [3:0] pullDown_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            outA_q <= LATCH_RESET;
            outB_q <= LATCH_RESET;
            outC_q <= LATCH_RESET[0];
        end else if (portWr) begin
            // ce reset and clock stop deliberately not listed here
            if (paddr == ADDR_OUT_PORT_A) outA_q <= wrNib;
            if (paddr == ADDR_OUT_PORT_B) outB_q <= wrNib;
            if (paddr == ADDR_OUT_PORT_C) outC_q <= wrNib[0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pullDown_q <= PULL_DOWN_RESET;
        end else if (portWr && paddr == ADDR_PULL_DOWN) begin
            pullDown_q <= wrNib;
        end
    end

    // ****************************************************************
    // pin drive: every output straight from a flip-flop
    // ****************************************************************
    always_comb begin
        bidirOut       = '{portB: latchB_q, portC: latchC_q, portD: latchD_q};
        bidirOe.portB  = dirB_q;
        bidirOe.portC  = dirCD_q[DIR_C_LSB +: 2];
        bidirOe.portD  = dirCD_q[DIR_D_LSB +: 2];
        outPins        = '{portA: outA_q, portB: outB_q, portC: outC_q};
        pullDownEn     = pullDown_q;
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    function automatic logic [3:0] pick(input logic [3:0] dir, input logic [3:0] lat,
                                        input logic [3:0] pin);
        pick = (dir & lat) | (~dir & pin);
    endfunction : pick

    logic [3:0] rdNib;
    logic [3:0] pickCD;

    // ports c and d share one select register, so one pick serves both halves
    assign pickCD = pick(dirCD_q, {latchD_q, latchC_q}, {bidirIn.portD, bidirIn.portC});
    always_comb begin
        case (paddr)
            ADDR_OUT_PORT_A:   rdNib = outA_q;
            ADDR_BIDIR_PORT_B: rdNib = pick(dirB_q, latchB_q, bidirIn.portB);
            ADDR_BIDIR_PORT_C: rdNib = {2'b00, pickCD[1:0]};
            ADDR_BIDIR_PORT_D: rdNib = {pickCD[3:2], 2'b00};
            ADDR_IN_PORT_A:    rdNib = inPortA;
            ADDR_OUT_PORT_B:   rdNib = outB_q;
            ADDR_OUT_PORT_C:   rdNib = {3'b000, outC_q};
            ADDR_DIR_B:        rdNib = dirB_q;
            ADDR_DIR_CD:       rdNib = dirCD_q;
            ADDR_PULL_DOWN:    rdNib = pullDown_q;
            ADDR_CONTROL:      rdNib = {1'b0, halt_q, 2'b00};
            default:           rdNib = 4'h0;
        endcase
    end

    // ****************************************************************
    // apb answer: one access cycle, no extra wait states
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? {28'h000_0000, rdNib} : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_porWrite(logic [7:0] a);
        portWr && paddr == a;
    endsequence

    a_dir_event_clears: assert property (@(posedge mclk) disable iff (!reset_n)
        (ceEvent || stopEvent) |=> bidirOe == '0)
        else $error("direction not cleared by ce reset or clock stop");

    a_latch_kept_event: assert property (@(posedge mclk) disable iff (!reset_n)
        (ceEvent || stopEvent) |=> $stable(bidirOut) && $stable(outPins))
        else $error("latch changed on ce reset or clock stop");

    a_pulldown_kept: assert property (@(posedge mclk) disable iff (!reset_n)
        (ceEvent || stopEvent) |=> $stable(pullDownEn))
        else $error("pull-down changed on ce reset or clock stop");

    a_halt_holds_all: assert property (@(posedge mclk) disable iff (!reset_n)
        halt_q && !(ceEvent || stopEvent) |=> $stable(bidirOut) && $stable(bidirOe)
        && $stable(outPins) && $stable(pullDownEn))
        else $error("state moved during halt");

    a_input_write_latch: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_BIDIR_PORT_B) |=> bidirOut.portB == $past(wrNib))
        else $error("port b latch not written");

    a_outa_write: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_OUT_PORT_A) |=> outPins.portA == $past(wrNib))
        else $error("output port a latch not written");

    a_dir_cd_split: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_DIR_CD) |=> bidirOe.portC == $past(wrNib[1:0])
        && bidirOe.portD == $past(wrNib[3:2]))
        else $error("shared direction register misrouted");

    a_read_input_pin: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && !pwrite && paddr == ADDR_BIDIR_PORT_B && dirB_q == 4'h0
        |=> prdata[3:0] == $past(bidirIn.portB) && pready)
        else $error("input pin level not returned");

    a_read_out_latch: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && !pwrite && paddr == ADDR_BIDIR_PORT_B && dirB_q == 4'hF
        |=> prdata[3:0] == latchB_q)
        else $error("latch not returned for output pin");

    a_in_port_ro: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && !pwrite && paddr == ADDR_IN_PORT_A
        |=> prdata == {28'h000_0000, $past(inPortA)})
        else $error("input-only port read wrong");

    a_unpinned_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && !pwrite && paddr == ADDR_BIDIR_PORT_C |=> prdata[31:2] == 30'h0)
        else $error("unpinned bits not zero");

    a_outb_write: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_OUT_PORT_B) |=> outPins.portB == $past(wrNib))
        else $error("output port b latch not written");

    a_pulldown_write: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_PULL_DOWN) |=> pullDownEn == $past(wrNib))
        else $error("pull-down select not written");

    a_port_c_write: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_BIDIR_PORT_C) |=> bidirOut.portC == $past(wrNib[1:0]))
        else $error("port c latch not written");

    a_dir_b_write: assert property (@(posedge mclk) disable iff (!reset_n)
        s_porWrite(ADDR_DIR_B) |=> bidirOe.portB == $past(wrNib))
        else $error("port b direction not written");

    a_read_out_only: assert property (@(posedge mclk) disable iff (!reset_n)
        setup && !pwrite && paddr == ADDR_OUT_PORT_B
        |=> prdata == {28'h000_0000, $past(outPins.portB)})
        else $error("output-only port read wrong");

    a_por_state: assert property (@(posedge mclk)
        !reset_n |=> bidirOe == '0 && bidirOut == '0 && outPins == '0
        && pullDownEn == PULL_DOWN_RESET)
        else $error("power-on state wrong");

endmodule : port_block
`default_nettype wire

/* File: testbench/pin_side_model.sv */
// external circuits that drive and sense the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
    // clock
    input  wire logic                    mclk,
    // device side
    input  wire port_block_pkg::bidir_t  bidirOut,
    input  wire port_block_pkg::bidir_t  bidirOe,
    input  wire logic [3:0]              pullDownEn,
    output port_block_pkg::bidir_t       bidirIn,
    output logic      [3:0]              inPortA,
    // external drivers
    input  wire logic [7:0]              extDrive,
    input  wire logic [7:0]              extLevel,
    input  wire logic [3:0]              inDrive,
    input  wire logic [3:0]              inLevel
);
    import port_block_pkg::*;
    // an undriven line wanders every cycle so a stale value never passes
    logic [7:0] floatPat_q = 8'hA5;

    always @(posedge mclk) begin
        floatPat_q <= ~floatPat_q;
    end

    // device wins where it drives, else the outside circuit, else a floating line
    assign bidirIn = (bidirOut & bidirOe) | (extLevel & extDrive & ~bidirOe)
                   | (floatPat_q & ~extDrive & ~bidirOe);
    assign inPortA = (inLevel & inDrive) | (floatPat_q[3:0] & ~inDrive & ~pullDownEn);
endmodule : pin_side_model
`default_nettype wire

/* File: testbench/four_bit_mcu_port_block_tb.sv */
// self-checking testbench of the general-purpose port block
`timescale 1ns/1ps
`default_nettype none
module four_bit_mcu_port_block_tb;
    import port_block_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bidir_t bidirIn, bidirOut, bidirOe;
    logic [3:0] inPortA, pullDownEn;
    outPins_t outPins;
    logic [7:0] extDrive = 8'h00;
    logic [7:0] extLevel = 8'h00;
    logic [3:0] inDrive = 4'h0;
    logic [3:0] inLevel = 4'h0;
    int miscompares = 0;
    int nCompared = 0;

    always #20 mclk = ~mclk;

    port_block dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bidirIn(bidirIn), .bidirOut(bidirOut), .bidirOe(bidirOe),
        .inPortA(inPortA), .pullDownEn(pullDownEn), .outPins(outPins));
    pin_side_model pins (.mclk(mclk), .bidirOut(bidirOut), .bidirOe(bidirOe),
        .pullDownEn(pullDownEn), .bidirIn(bidirIn), .inPortA(inPortA), .extDrive(extDrive),
        .extLevel(extLevel), .inDrive(inDrive), .inLevel(inLevel));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        logic ok;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        ok = (pready === 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // return mid-cycle so callers see outputs that the access edge launched
        @(negedge mclk);
        if (!ok) begin
            miscompares++;
            stop_test();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {28'h0, d}, r, e);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [3:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, {28'h0, exp});
    endtask : rdc

    function automatic logic [3:0] mix(input logic [3:0] l, d, p);
        return (l & d) | (p & ~d);
    endfunction : mix

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic [3:0] a, b, c, dir, cd, lat, l2, lvl, lv2, pd, m;
        logic [31:0] r;
        logic e;
        void'($urandom(32'hda64));
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        check({23'h0, outPins}, 32'h0);
        check({24'h0, bidirOe}, 32'h0);
        check({28'h0, pullDownEn}, 32'hF);
        rdc(ADDR_DIR_B, 4'h0);
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
            b = 4'($urandom);
            c = (i == 0) ? 4'hF : 4'($urandom);
            wr(ADDR_OUT_PORT_A, a);
            wr(ADDR_OUT_PORT_B, b);
            wr(ADDR_OUT_PORT_C, c);
            check({23'h0, outPins}, {23'h0, a, b, c[0]});
            rdc(ADDR_OUT_PORT_A, a);
            rdc(ADDR_OUT_PORT_B, b);
            rdc(ADDR_OUT_PORT_C, {3'b000, c[0]});
        end
        for (int i = 0; i < 8; i++) begin
            dir = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            cd = (i == 0) ? 4'h0 : 4'($urandom);
            lat = 4'($urandom);
            l2 = 4'($urandom);
            lvl = 4'($urandom);
            lv2 = 4'($urandom);
            wr(ADDR_BIDIR_PORT_B, lat);
            wr(ADDR_BIDIR_PORT_C, l2);
            wr(ADDR_BIDIR_PORT_D, l2);
            wr(ADDR_DIR_B, dir);
            wr(ADDR_DIR_CD, cd);
            @(posedge mclk);
            extDrive <= ~{dir, cd[1:0], cd[3:2]};
            extLevel <= {lvl, lv2[1:0], lv2[3:2]};
            check({24'h0, bidirOe}, {24'h0, dir, cd[1:0], cd[3:2]});
            check({24'h0, bidirOut}, {24'h0, lat, l2[1:0], l2[3:2]});
            rdc(ADDR_BIDIR_PORT_B, mix(lat, dir, lvl));
            m = mix(l2, cd, lv2);
            rdc(ADDR_BIDIR_PORT_C, {2'b00, m[1:0]});
            rdc(ADDR_BIDIR_PORT_D, {m[3:2], 2'b00});
        end
        for (int i = 0; i < 4; i++) begin
            pd = 4'($urandom);
            lvl = 4'($urandom);
            wr(ADDR_PULL_DOWN, pd);
            check({28'h0, pullDownEn}, {28'h0, pd});
            @(posedge mclk);
            inDrive <= ~pd;
            inLevel <= lvl;
            wr(ADDR_IN_PORT_A, ~lvl);
            rdc(ADDR_IN_PORT_A, lvl & ~pd);
        end
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_DIR_B, 4'hF);
            wr(ADDR_DIR_CD, 4'hF);
            wr(ADDR_CONTROL, 4'(1 << k));
            check({24'h0, bidirOe}, 32'h0);
            check({24'h0, bidirOut}, {24'h0, lat, l2[1:0], l2[3:2]});
            check({23'h0, outPins}, {23'h0, a, b, c[0]});
            check({28'h0, pullDownEn}, {28'h0, pd});
            rdc(ADDR_DIR_CD, 4'h0);
        end
        wr(ADDR_DIR_B, 4'hF);
        wr(ADDR_CONTROL, 4'h4);
        wr(ADDR_OUT_PORT_A, ~a);
        wr(ADDR_BIDIR_PORT_B, ~lat);
        wr(ADDR_DIR_B, 4'h0);
        wr(ADDR_PULL_DOWN, ~pd);
        check({23'h0, outPins}, {23'h0, a, b, c[0]});
        check({24'h0, bidirOe}, 32'hF0);
        check({24'h0, bidirOut}, {24'h0, lat, l2[1:0], l2[3:2]});
        check({28'h0, pullDownEn}, {28'h0, pd});
        rdc(ADDR_CONTROL, 4'h4);
        wr(ADDR_CONTROL, 4'h0);
        wr(ADDR_OUT_PORT_A, ~a);
        check({23'h0, outPins}, {23'h0, ~a, b, c[0]});
        apb(1'b0, 8'h30, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        // second power-on reset in mid-run must clear what the scenarios left set
        @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        check({23'h0, outPins}, 32'h0);
        check({24'h0, bidirOe}, 32'h0);
        check({24'h0, bidirOut}, 32'h0);
        check({28'h0, pullDownEn}, 32'hF);
        stop_test();
    end
endmodule : four_bit_mcu_port_block_tb
`default_nettype wire
